// file: verilog/stepper_chain_refswitch_config.sv
// How it works
// - Split clear: one shared select for all
// - Split set: three selects, all active low
// - Chain clock is clock over 2(divider+1)
// - Divider below seven: same rate, asymmetric
// - Divider resets to fifteen
// - Refresh clear: send only on demand
// - Switches sampled only during datagram frames
// - Refresh set: periodic frames at ramp rate
// - Halted motor resumes when switch reads inactive
// - Shared select also steers switch multiplexer
// - Mux set: six switches, right bit ignored
// - Default: inputs are left switches only
// - Right bit: input three is motor one right
// - Mux and right bit reset to zero
// - Nonzero tolerance suppresses stop near reference
// - Re-armed latch captures position at switch edge
// - Stop enabled: motor stops at active switch in its direction of travel
// - Shared select polarity bit: zero low active
`include "stepper_chain_defines.svh"
`default_nettype none
module stepper_chain_refswitch_config
   import stepper_chain_pkg::*;
(
   // Clock and reset
   input  wire logic        clk_sys,
   input  wire logic        arst_n,
   // Register bus
   input  wire apb_req_s    apbReq,
   output apb_rsp_s         apbRsp,
   // Motion logic side
   input  wire logic        newDataDemand,
   input  wire logic [2:0]  motorMoving,
   input  wire logic [2:0]  motorDirPos,
   input  wire logic [71:0] actualPos,
   input  wire logic [11:0] rampDiv,
   input  wire logic [47:0] txDatagram,
   output logic [2:0]       stopMotor,
   output logic             frameBusy,
   // Switch pins
   input  wire logic        switch_input_one,
   input  wire logic        switch_input_two,
   input  wire logic        switch_input_three,
   // Driver chain pins
   output logic             chainSelect,
   output logic             chain_select_second_n,
   output logic             chain_select_third_n,
   output logic             chainClock,
   output logic             chainDataOut
);
   // ----------
   // State
   // ----------
   typedef struct packed {
      cfg_s         cfg;        // Configuration word
      logic [11:0]  tol;        // reference_tolerance
      frame_state_e st;         // Frame sequencer
      logic         pending;    // Frame requested
      logic [18:0]  acc;        // Refresh rate accumulator
      logic [6:0]   divFrame;   // Divider used by current frame
      logic [47:0]  shift;      // Outgoing datagram
      logic [5:0]   bitCnt;     // Bits sent in frame
      logic [4:0]   gapCnt;     // Cycles in trailing gap
      logic [2:0]   sync1;      // Switch synchroniser, first
      logic [2:0]   sync2;      // Switch synchroniser, second
      logic [2:0]   armed;      // Position latch armed
      logic [71:0]  latched;    // Captured positions
      logic [2:0]   prevHit;    // Previous switch activity
      logic [2:0]   stop;       // Stop requests
      logic [31:0]  rdata;      // Read data
      logic         pinSel;     // Shared select pin
      logic         pinSel2n;   // Second select pin
      logic         pinSel3n;   // Third select pin
      logic         pinSck;     // Chain clock pin
      logic         pinData;    // Chain data pin
   } top_s;
   top_s          s_q;          // Registered state
   top_s          s_d;          // Next state
   logic          sckHigh;      // Generated chain clock
   logic          bitDone;      // End of one bit period
   logic          sampleLeft;   // Sample strobe, select active
   logic          sampleRight;  // Sample strobe, select released
   switch_state_s sw;           // Demultiplexed switches
   logic [2:0]    hit;          // Switch in direction of travel
   logic [2:0]    anySw;        // Any switch of a motor active
   logic [2:0]    nearRef;      // Within tolerance window
   logic [18:0]   rateSum;      // Sum of two to ramp divs
   logic          busAccess;    // APB access phase
   logic          busWrite;     // Write takes effect
   logic          addrOk;       // Mapped address
   logic          frameStart;   // Frame begins this cycle
   logic          refreshTick;  // Periodic frame request
   logic          selActive;    // Frame select phase
   // ----------
   // Clock generator and switch mapper
   // ----------
   chain_clock_gen u_clk
   (
      .clk_sys (clk_sys),
      .arst_n  (arst_n),
      .run     (s_q.st == ST_SHIFT),
      .divider (s_q.divFrame),
      .sckHigh (sckHigh),
      .bitDone (bitDone)
   );
   ref_switch_map u_map
   (
      .clk_sys      (clk_sys),
      .arst_n       (arst_n),
      .swIn         (s_q.sync2),
      .sampleLeft   (sampleLeft),
      .sampleRight  (sampleRight),
      .mux          (s_q.cfg.mux),
      .rightSwitch1 (s_q.cfg.rightSwitch1),
      .sw           (sw)
   );
   // ----------
   // Per motor switch, window and rate terms
   // ----------
   genvar k;
   generate
      for (k = 0; k < 3; k++)
      begin : g_motor
         logic [23:0] diff;   // Position minus captured position
         logic [23:0] mag;    // Magnitude of the difference
         assign anySw[k] = sw.left[k] | sw.right[k];
         assign hit[k]   = motorDirPos[k] ? sw.right[k] : sw.left[k];
         assign diff     = actualPos[24*k +: 24] - s_q.latched[24*k +: 24];
         assign mag      = diff[23] ? (24'h0 - diff) : diff;
         assign nearRef[k] = (s_q.tol != 12'h000) && (mag <= {12'h000, s_q.tol});
      end
   endgenerate
   // Refresh rate sums two to each ramp prescale
   always_comb
   begin
      rateSum = 19'h0;
      for (int m = 0; m < 3; m++)
      begin
         rateSum = rateSum + (19'h1 << rampDiv[4*m +: 4]);
      end
   end
   // ----------
   // Bus decode
   // ----------
   always_comb
   begin
      busAccess = apbReq.psel && apbReq.penable;
      busWrite  = busAccess && apbReq.pwrite;
      unique case (apbReq.paddr)
         `ADDR_CONFIG, `ADDR_SWITCHES, `ADDR_TOLERANCE,
         `ADDR_LATCH0, `ADDR_LATCH1, `ADDR_LATCH2: addrOk = 1'b1;
         default:                                  addrOk = 1'b0;
      endcase
   end
   // Zero wait states, read data prepared in setup
   assign apbRsp.pready  = busAccess;
   assign apbRsp.pslverr = busAccess && !addrOk;
   assign apbRsp.prdata  = s_q.rdata;
   // ----------
   // Next state
   // ----------
   always_comb
   begin
      s_d         = s_q;
      sampleLeft  = 1'b0;
      sampleRight = 1'b0;
      // Two flops on the switch pins
      s_d.sync1 = {switch_input_three, switch_input_two, switch_input_one};
      s_d.sync2 = s_q.sync1;
      // Periodic request from the accumulator
      refreshTick = 1'b0;
      if (!s_q.cfg.refresh)
      begin
         s_d.acc = 19'h0;
      end
      else if (s_q.acc + rateSum >= `REFRESH_FULL)
      begin
         s_d.acc     = s_q.acc + rateSum - `REFRESH_FULL;
         refreshTick = 1'b1;
      end
      else
      begin
         s_d.acc = s_q.acc + rateSum;
      end
      frameStart = (s_q.st == ST_IDLE) && s_q.pending;
      // New request wins over the clear at frame start
      s_d.pending = newDataDemand || refreshTick || (s_q.pending && !frameStart);
      // Frame sequencer
      unique case (s_q.st)
         ST_IDLE:
         begin
            if (frameStart)
            begin
               s_d.divFrame = s_q.cfg.divider;
               s_d.shift    = txDatagram;
               s_d.bitCnt   = 6'h00;
               s_d.st       = ST_SHIFT;
            end
         end
         ST_SHIFT:
         begin
            if (bitDone)
            begin
               // Left set sampled while select is active
               sampleLeft = (s_q.bitCnt == 6'h00);
               s_d.shift  = {s_q.shift[46:0], 1'b0};
               s_d.bitCnt = s_q.bitCnt + 6'h01;
               if (s_q.bitCnt == `FRAME_LAST)
               begin
                  s_d.gapCnt = 5'h00;
                  s_d.st     = ST_GAP;
               end
            end
         end
         ST_GAP:
         begin
            s_d.gapCnt = s_q.gapCnt + 5'h01;
            if (s_q.gapCnt == `GAP_LAST)
            begin
               // Right set sampled after select released
               sampleRight = 1'b1;
               s_d.st      = ST_IDLE;
            end
         end
      endcase
      // Automatic stop follows each sampled switch state
      s_d.stop = s_q.cfg.stopEnable & hit & ~nearRef;
      // Position capture on a rising switch edge
      s_d.prevHit = anySw;
      for (int m = 0; m < 3; m++)
      begin
         if (s_q.armed[m] && motorMoving[m] && anySw[m] && !s_q.prevHit[m])
         begin
            s_d.latched[24*m +: 24] = actualPos[24*m +: 24];
            s_d.armed[m]            = 1'b0;
         end
      end
      // Register writes
      if (busWrite)
      begin
         unique case (apbReq.paddr)
            `ADDR_CONFIG:
            begin
               s_d.cfg.split        = apbReq.pwdata[`CFG_SPLIT];
               s_d.cfg.selPol       = apbReq.pwdata[`CFG_SEL_POL];
               s_d.cfg.sckPol       = apbReq.pwdata[`CFG_SCK_POL];
               s_d.cfg.refresh      = apbReq.pwdata[`CFG_REFRESH];
               s_d.cfg.mux          = apbReq.pwdata[`CFG_MUX];
               s_d.cfg.rightSwitch1 = apbReq.pwdata[`CFG_RIGHT1];
               s_d.cfg.stopEnable   = apbReq.pwdata[`CFG_STOP_MSB:`CFG_STOP_LSB];
               s_d.cfg.divider      = apbReq.pwdata[`CFG_DIV_MSB:`CFG_DIV_LSB];
            end
            `ADDR_TOLERANCE: s_d.tol = apbReq.pwdata[11:0];
            // Any write re-arms the capture
            `ADDR_LATCH0: s_d.armed[0] = 1'b1;
            `ADDR_LATCH1: s_d.armed[1] = 1'b1;
            `ADDR_LATCH2: s_d.armed[2] = 1'b1;
            default:      s_d.armed = s_d.armed;
         endcase
      end
      // Read data latched in the setup cycle
      if (apbReq.psel && !apbReq.penable)
      begin
         s_d.rdata = 32'h0;
         unique case (apbReq.paddr)
            `ADDR_CONFIG:
            begin
               s_d.rdata[`CFG_SPLIT]   = s_q.cfg.split;
               s_d.rdata[`CFG_SEL_POL] = s_q.cfg.selPol;
               s_d.rdata[`CFG_SCK_POL] = s_q.cfg.sckPol;
               s_d.rdata[`CFG_REFRESH] = s_q.cfg.refresh;
               s_d.rdata[`CFG_MUX]     = s_q.cfg.mux;
               s_d.rdata[`CFG_RIGHT1]  = s_q.cfg.rightSwitch1;
               s_d.rdata[`CFG_STOP_MSB:`CFG_STOP_LSB] = s_q.cfg.stopEnable;
               s_d.rdata[`CFG_DIV_MSB:`CFG_DIV_LSB]   = s_q.cfg.divider;
            end
            `ADDR_SWITCHES:
            begin
               s_d.rdata[5:0] = {sw.left[2], sw.right[2], sw.left[1],
                                 sw.right[1], sw.left[0], sw.right[0]};
            end
            `ADDR_TOLERANCE: s_d.rdata[11:0] = s_q.tol;
            `ADDR_LATCH0:
            begin
               s_d.rdata[23:0]         = s_q.latched[23:0];
               s_d.rdata[`LATCH_ARMED] = s_q.armed[0];
            end
            `ADDR_LATCH1:
            begin
               s_d.rdata[23:0]         = s_q.latched[47:24];
               s_d.rdata[`LATCH_ARMED] = s_q.armed[1];
            end
            `ADDR_LATCH2:
            begin
               s_d.rdata[23:0]         = s_q.latched[71:48];
               s_d.rdata[`LATCH_ARMED] = s_q.armed[2];
            end
            default: s_d.rdata = 32'h0;
         endcase
      end
      // Chain pins, one cycle behind the sequencer
      selActive  = (s_q.st == ST_SHIFT);
      s_d.pinSck  = sckHigh ^ s_q.cfg.sckPol;
      s_d.pinData = selActive && s_q.shift[47];
      if (s_q.cfg.split)
      begin
         // Individual selects, fixed active low
         s_d.pinSel   = !(selActive && s_q.bitCnt < `SEG_SECOND);
         s_d.pinSel2n = !(selActive && s_q.bitCnt >= `SEG_SECOND
                          && s_q.bitCnt < `SEG_THIRD);
         s_d.pinSel3n = !(selActive && s_q.bitCnt >= `SEG_THIRD);
      end
      else
      begin
         // One shared select, programmable polarity
         s_d.pinSel   = s_q.cfg.selPol ? selActive : !selActive;
         s_d.pinSel2n = 1'b1;
         s_d.pinSel3n = 1'b1;
      end
   end
   // ----------
   // State register
   // ----------
   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         s_q              <= '0;
         s_q.st           <= ST_IDLE;
         s_q.cfg.divider  <= `DIV_RESET;
         s_q.cfg.mux      <= 1'b0;
         s_q.cfg.rightSwitch1 <= 1'b0;
         s_q.divFrame     <= `DIV_RESET;
         s_q.pinSel       <= 1'b1;
         s_q.pinSel2n     <= 1'b1;
         s_q.pinSel3n     <= 1'b1;
      end
      else
      begin
         s_q <= s_d;
      end
   end
   // ----------
   // Outputs
   // ----------
   assign stopMotor             = s_q.stop;
   assign frameBusy             = (s_q.st != ST_IDLE);
   assign chainSelect           = s_q.pinSel;
   assign chain_select_second_n = s_q.pinSel2n;
   assign chain_select_third_n  = s_q.pinSel3n;
   assign chainClock            = s_q.pinSck;
   assign chainDataOut          = s_q.pinData;
endmodule : stepper_chain_refswitch_config
`default_nettype wire

// file: verilog/stepper_chain_defines.svh
`ifndef STEPPER_CHAIN_DEFINES_SVH
`define STEPPER_CHAIN_DEFINES_SVH
// ----------
// Register byte addresses
// ----------
`define ADDR_CONFIG    8'h00
`define ADDR_SWITCHES  8'h04
`define ADDR_TOLERANCE 8'h08
`define ADDR_LATCH0    8'h10
`define ADDR_LATCH1    8'h14
`define ADDR_LATCH2    8'h18
// ----------
// Configuration word field positions
// ----------
`define CFG_SPLIT      0
`define CFG_SEL_POL    1
`define CFG_SCK_POL    2
`define CFG_REFRESH    3
`define CFG_MUX        4
`define CFG_RIGHT1     5
`define CFG_STOP_LSB   8
`define CFG_STOP_MSB   10
`define CFG_DIV_LSB    16
`define CFG_DIV_MSB    22
`define LATCH_ARMED    31
// ----------
// Reset values and timing counts
// ----------
`define DIV_RESET      7'h0f
`define DIV_MIN        7'h07
`define DIV_PERIOD_SUM 7'h0e
`define FRAME_LAST     6'h2f
`define SEG_SECOND     6'h10
`define SEG_THIRD      6'h20
`define GAP_LAST       5'h10
`define REFRESH_FULL   19'h08000
`endif

// file: verilog/stepper_chain_pkg.sv
`default_nettype none
package stepper_chain_pkg;
   // ----------
   // Frame sequencer states
   // ----------
   typedef enum logic [2:0]
   {
      ST_IDLE  = 3'b001,
      ST_SHIFT = 3'b010,
      ST_GAP   = 3'b100
   } frame_state_e;
   // ----------
   // Carriers
   // ----------
   typedef struct packed {
      logic [6:0] divider;       // Chain clock divider
      logic [2:0] stopEnable;    // Per motor automatic stop
      logic       rightSwitch1;  // first_axis_right_switch
      logic       mux;           // Switch multiplexing
      logic       refresh;       // Periodic refresh
      logic       sckPol;        // Chain clock inversion
      logic       selPol;        // Shared select polarity
      logic       split;         // select_split
   } cfg_s;
   typedef struct packed {
      logic       psel;
      logic       penable;
      logic       pwrite;
      logic [7:0] paddr;
      logic [31:0] pwdata;
   } apb_req_s;
   typedef struct packed {
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
   } apb_rsp_s;
   typedef struct packed {
      logic [2:0] left;          // Left switch per motor
      logic [2:0] right;         // Right switch per motor
   } switch_state_s;
endpackage : stepper_chain_pkg
`default_nettype wire

// file: verilog/chain_clock_gen.sv
`include "stepper_chain_defines.svh"
`default_nettype none
module chain_clock_gen
   import stepper_chain_pkg::*;
(
   // Clock and reset
   input  wire logic       clk_sys,
   input  wire logic       arst_n,
   // Control
   input  wire logic       run,
   input  wire logic [6:0] divider,
   // Generated clock
   output logic            sckHigh,
   output logic            bitDone
);
   // ----------
   // State
   // ----------
   typedef struct packed {
      logic [6:0] count;   // Cycles spent in current phase
      logic       high;    // Current phase
   } clkgen_s;
   clkgen_s    s_q;         // Registered state
   clkgen_s    s_d;         // Next state
   logic [6:0] lowLast;     // Last count of the low phase
   // Low phase stretches below the minimum divider
   always_comb
   begin
      if (divider < `DIV_MIN)
      begin
         lowLast = `DIV_PERIOD_SUM - divider;
      end
      else
      begin
         lowLast = divider;
      end
   end
   // Low phase then high phase, each count+1 cycles
   always_comb
   begin
      s_d     = s_q;
      bitDone = 1'b0;
      if (!run)
      begin
         s_d = '0;
      end
      else if (!s_q.high && s_q.count == lowLast)
      begin
         s_d.count = '0;
         s_d.high  = 1'b1;
      end
      else if (s_q.high && s_q.count == divider)
      begin
         s_d.count = '0;
         s_d.high  = 1'b0;
         bitDone   = 1'b1;
      end
      else
      begin
         s_d.count = s_q.count + 7'h01;
      end
   end
   // State register
   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         s_q <= '0;
      end
      else
      begin
         s_q <= s_d;
      end
   end
   assign sckHigh = s_q.high;
endmodule : chain_clock_gen
`default_nettype wire

// file: verilog/ref_switch_map.sv
`default_nettype none
module ref_switch_map
   import stepper_chain_pkg::*;
(
   // Clock and reset
   input  wire logic       clk_sys,
   input  wire logic       arst_n,
   // Synchronised switch inputs
   input  wire logic [2:0] swIn,
   input  wire logic       sampleLeft,
   input  wire logic       sampleRight,
   // Configuration
   input  wire logic       mux,
   input  wire logic       rightSwitch1,
   // Demultiplexed switch state
   output switch_state_s   sw
);
   switch_state_s s_q;   // Registered switch state
   switch_state_s s_d;   // Next switch state
   // Association of inputs to motor switches
   always_comb
   begin
      s_d = s_q;
      if (mux)
      begin
         if (sampleLeft)
         begin
            s_d.left = swIn;
         end
         if (sampleRight)
         begin
            s_d.right = swIn;
         end
      end
      else if (sampleLeft)
      begin
         if (rightSwitch1)
         begin
            s_d.left  = {1'b0, swIn[1:0]};
            s_d.right = {2'b00, swIn[2]};
         end
         else
         begin
            s_d.left  = swIn;
            s_d.right = 3'h0;
         end
      end
   end
   // State register
   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         s_q <= '0;
      end
      else
      begin
         s_q <= s_d;
      end
   end
   assign sw = s_q;
endmodule : ref_switch_map
`default_nettype wire

// file: sim/chain_cfg_asserts.sv
`default_nettype none
module chain_cfg_asserts
   import stepper_chain_pkg::*;
(
   // Clock, reset and bus
   input  wire logic     clk_sys,
   input  wire logic     arst_n,
   input  wire apb_req_s apbReq,
   input  wire apb_rsp_s apbRsp,
   // Chain side
   input  wire logic     frameBusy,
   input  wire logic     chainSelect,
   input  wire logic     chain_select_second_n,
   input  wire logic     chain_select_third_n,
   input  wire logic     chainClock,
   input  wire logic     chainDataOut
);
   // Cycles since the last chain clock rise, saturating
   logic [5:0] sinceRise_q;
   always_ff @(posedge clk_sys or negedge arst_n)
      if (!arst_n)
         sinceRise_q <= 6'h3f;
      else if ($rose(chainClock))
         sinceRise_q <= 6'h00;
      else if (sinceRise_q != 6'h3f)
         sinceRise_q <= sinceRise_q + 6'h01;
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!arst_n);
   zero_wait_a: assert property (apbReq.psel && apbReq.penable |-> apbRsp.pready)
      else $error("pready missing in access phase");
   err_access_a: assert property (apbRsp.pslverr |-> apbReq.psel && apbReq.penable)
      else $error("pslverr outside access phase");
   idle_selects_a: assert property (!frameBusy |-> chain_select_second_n && chain_select_third_n)
      else $error("driver select active while idle");
   idle_data_a: assert property (!frameBusy |-> !chainDataOut)
      else $error("chain data high while idle");
   frame_start_a: assert property ($rose(frameBusy) |=> $changed(chainSelect))
      else $error("shared select did not follow frame start");
   clock_period_a: assert property ($rose(chainClock) |-> sinceRise_q >= 6'h0f)
      else $error("chain clock period too short");
   second_seg_a: assert property ($fell(chain_select_second_n) |-> chainSelect && chain_select_third_n)
      else $error("second driver select overlaps");
   third_seg_a: assert property ($fell(chain_select_third_n) |-> !$past(chain_select_second_n) && chain_select_second_n)
      else $error("third driver select out of order");
endmodule : chain_cfg_asserts
bind stepper_chain_refswitch_config chain_cfg_asserts u_asserts (.clk_sys(clk_sys),
   .arst_n(arst_n), .apbReq(apbReq), .apbRsp(apbRsp), .frameBusy(frameBusy),
   .chainSelect(chainSelect), .chain_select_second_n(chain_select_second_n),
   .chain_select_third_n(chain_select_third_n), .chainClock(chainClock),
   .chainDataOut(chainDataOut));
`default_nettype wire

// file: sim/chain_driver_model.sv
`default_nettype none
module chain_driver_model
(
   // Chain pins and shared select level
   input  wire logic   chainSelect,
   input  wire logic   chain_select_second_n,
   input  wire logic   chain_select_third_n,
   input  wire logic   chainClock,
   input  wire logic   chainDataOut,
   input  wire logic   selHigh,
   // Received word, bit count, last bit period
   output logic [47:0] word,
   output int          bits,
   output time         period
);
   timeunit 1ns;
   timeprecision 1ps;
   time last = 0;
   initial bits = 0;
   // Frame begins when the shared select turns active
   always @(posedge (chainSelect === selHigh))
      bits = 0;
   // Shift on clock rise while any driver is selected
   always @(posedge chainClock)
      if (chainSelect === selHigh || !chain_select_second_n || !chain_select_third_n)
      begin
         word = {word[46:0], chainDataOut};
         bits = bits + 1;
         period = $time - last;
         last = $time;
      end
endmodule : chain_driver_model
`default_nettype wire

// file: sim/test_stepper_chain_refswitch_config.sv
`include "stepper_chain_defines.svh"
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin bad_count++; \
   $display("ERROR %0t mismatch %0h vs %0h", $time, a, b); end end
module test_stepper_chain_refswitch_config
   import stepper_chain_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed {logic w; logic [7:0] a; logic [31:0] d; logic [31:0] x; logic e;} row_s;
   logic clk_sys = 0, arst_n = 0, newDataDemand = 0, selHigh = 0, muxOn = 0, er;
   logic [2:0] motorMoving = 0, motorDirPos = 0, sw = 0, leftSw = 3'h1, rightSw = 3'h4, snap;
   logic [71:0] actualPos = 0;
   logic [11:0] rampDiv = 0;
   logic [47:0] txDatagram = 48'ha5c30f96e1b7, word;
   logic [31:0] rd;
   logic [2:0] stopMotor;
   logic frameBusy, chainSelect, chain_select_second_n, chain_select_third_n, chainClock, chainDataOut;
   apb_req_s apbReq = '0;
   apb_rsp_s apbRsp;
   int bad_count = 0, checked = 0, bits, starts = 0, s0;
   time period;
   row_s rows [12] = '{ {1'b0, `ADDR_CONFIG, 32'h0, 32'h000f0000, 1'b0},
      {1'b0, `ADDR_SWITCHES, 32'h0, 32'h0, 1'b0}, {1'b0, `ADDR_LATCH0, 32'h0, 32'h0, 1'b0},
      {1'b1, `ADDR_TOLERANCE, 32'hffffffff, 32'h0, 1'b0},
      {1'b0, `ADDR_TOLERANCE, 32'h0, 32'h00000fff, 1'b0},
      {1'b1, `ADDR_SWITCHES, 32'h3f, 32'h0, 1'b0}, {1'b0, `ADDR_SWITCHES, 32'h0, 32'h0, 1'b0},
      {1'b0, 8'h0c, 32'h0, 32'h0, 1'b1}, {1'b1, 8'h0c, 32'h1, 32'h0, 1'b1},
      {1'b1, `ADDR_LATCH1, 32'h0, 32'h0, 1'b0},
      {1'b0, `ADDR_LATCH1, 32'h0, 32'h80000000, 1'b0}, {1'b1, `ADDR_TOLERANCE, 32'h0, 32'h0, 1'b0} };
   stepper_chain_refswitch_config u_dut (.clk_sys(clk_sys), .arst_n(arst_n), .apbReq(apbReq),
      .apbRsp(apbRsp), .newDataDemand(newDataDemand), .motorMoving(motorMoving),
      .motorDirPos(motorDirPos), .actualPos(actualPos), .rampDiv(rampDiv),
      .txDatagram(txDatagram), .stopMotor(stopMotor), .frameBusy(frameBusy),
      .switch_input_one(sw[0]), .switch_input_two(sw[1]), .switch_input_three(sw[2]),
      .chainSelect(chainSelect), .chain_select_second_n(chain_select_second_n),
      .chain_select_third_n(chain_select_third_n), .chainClock(chainClock),
      .chainDataOut(chainDataOut));
   chain_driver_model u_chain (.chainSelect(chainSelect), .chainDataOut(chainDataOut),
      .chain_select_second_n(chain_select_second_n), .chain_select_third_n(chain_select_third_n),
      .chainClock(chainClock), .selHigh(selHigh), .word(word), .bits(bits), .period(period));
   initial forever #12.5 clk_sys = ~clk_sys;
   // External switch multiplexer steered by the shared select
   always @(posedge clk_sys) if (muxOn) sw <= chainSelect ? rightSw : leftSw;
   always @(posedge frameBusy) starts++;
   initial begin #1000000; bad_count++; test_done(); end
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      apbReq <= '{1'b1, 1'b0, w, a, d};
      @(posedge clk_sys);
      apbReq.penable <= 1'b1;
      do @(posedge clk_sys); while (apbRsp.pready !== 1'b1);
      rd = apbRsp.prdata;
      er = apbRsp.pslverr;
      apbReq <= '0;
      @(posedge clk_sys);
   endtask : apb
   task rchk(input logic [7:0] a, input logic [31:0] x);
      apb(1'b0, a, 32'h0);
      `CHK(rd, x)
   endtask : rchk
   function automatic logic [31:0] cfg(input logic [6:0] dv, input logic [2:0] st, input logic [5:0] lo);
      return {9'h000, dv, 5'h00, st, 2'h0, lo};
   endfunction : cfg
   // Demand one frame, rewrite config in mid-frame, wait for idle
   task frame(input logic [31:0] mid);
      newDataDemand <= 1'b1;
      @(posedge clk_sys);
      newDataDemand <= 1'b0;
      repeat (4) @(posedge clk_sys);
      snap = {chainSelect, chain_select_second_n, chain_select_third_n};
      apb(1'b1, `ADDR_CONFIG, mid);
      while (frameBusy === 1'b1) @(posedge clk_sys);
      repeat (4) @(posedge clk_sys);
   endtask : frame
   task test_done();
      $display("checked %0d bad_count %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : test_done
   initial begin
      repeat (20) @(posedge clk_sys);
      `CHK({chainSelect, chain_select_second_n, chain_select_third_n, chainClock, chainDataOut, frameBusy, stopMotor}, 9'h1c0)
      arst_n <= 1'b1;
      @(posedge clk_sys);
      foreach (rows[i]) begin
         apb(rows[i].w, rows[i].a, rows[i].d);
         `CHK(er, rows[i].e)
         if (!rows[i].w) `CHK(rd, rows[i].x)
      end
      frame(cfg(7'h0f, 3'h0, 6'h00));
      `CHK({snap, word, period}, {3'h3, txDatagram, 64'h320})
      selHigh <= 1'b1;
      apb(1'b1, `ADDR_CONFIG, cfg(7'h07, 3'h0, 6'h02));
      frame(cfg(7'h07, 3'h0, 6'h02));
      `CHK({snap, word, period}, {3'h7, txDatagram, 64'h190})
      selHigh <= 1'b0;
      apb(1'b1, `ADDR_CONFIG, cfg(7'h03, 3'h0, 6'h01));
      frame(cfg(7'h7f, 3'h0, 6'h01));
      `CHK({snap, word, period, bits[7:0]}, {3'h3, txDatagram, 64'h190, 8'h30})
      apb(1'b1, `ADDR_CONFIG, cfg(7'h07, 3'h0, 6'h00));
      sw <= 3'h7;
      frame(cfg(7'h07, 3'h0, 6'h00));
      sw <= 3'h0;
      repeat (10) @(posedge clk_sys);
      rchk(`ADDR_SWITCHES, 32'h2a);
      sw <= 3'h4;
      frame(cfg(7'h07, 3'h0, 6'h20));
      rchk(`ADDR_SWITCHES, 32'h01);
      muxOn <= 1'b1;
      frame(cfg(7'h07, 3'h0, 6'h38));
      rchk(`ADDR_SWITCHES, 32'h12);
      muxOn <= 1'b0;
      sw <= 3'h0;
      motorMoving <= 3'h1;
      actualPos <= 72'h100;
      apb(1'b1, `ADDR_LATCH0, 32'h0);
      frame(cfg(7'h07, 3'h1, 6'h00));
      `CHK(stopMotor, 3'h0)
      sw <= 3'h1;
      frame(cfg(7'h07, 3'h1, 6'h00));
      `CHK(stopMotor, 3'h1)
      rchk(`ADDR_LATCH0, 32'h100);
      apb(1'b1, `ADDR_TOLERANCE, 32'h10);
      frame(cfg(7'h07, 3'h1, 6'h00));
      `CHK(stopMotor, 3'h0)
      actualPos <= 72'h200;
      frame(cfg(7'h07, 3'h1, 6'h00));
      `CHK(stopMotor, 3'h1)
      s0 = starts;
      sw <= 3'h0;
      repeat (3000) @(posedge clk_sys);
      `CHK({starts == s0, stopMotor}, 4'h9)
      rampDiv <= 12'h00f;
      apb(1'b1, `ADDR_CONFIG, cfg(7'h07, 3'h1, 6'h08));
      repeat (2000) @(posedge clk_sys);
      `CHK({starts > s0 + 1, stopMotor}, 4'h8)
      test_done();
   end
endmodule : test_stepper_chain_refswitch_config
`default_nettype wire
